// >>> logic/sensor_cfg_pkg.sv
// Constants and carrier types for the sensor configuration and status-clear register bank.
// Assumes a serial front end that decodes bus transactions into register strobes and CCC events.
package sensor_cfg_pkg;

   // Register offsets
   localparam logic [7:0] HOST_ID_CONFIG_ADDR = 8'h04;
   localparam logic [7:0] DEVICE_CONFIG_ADDR = 8'h12;
   localparam logic [7:0] TEMP_STATUS_CLEAR_ADDR = 8'h13;
   localparam logic [7:0] ERROR_STATUS_CLEAR_ADDR = 8'h14;
   localparam logic [7:0] SENSED_TEMP_LOW_BYTE_ADDR = 8'h31;

   // Reset values
   localparam logic [7:0] HOST_ID_CONFIG_RESET = 8'h0e;
   localparam logic [2:0] HOST_ASSIGNED_CODE_RESET = 3'h7;
   localparam logic [7:0] DEVICE_CONFIG_RESET = 8'h00;

   // Field positions inside device_config
   localparam int PACKET_CHECK_ENABLE_BIT = 7;
   localparam int PARITY_CHECK_DISABLE_BIT = 6;
   localparam int PROTOCOL_INDICATOR_BIT = 5;
   localparam int DEFAULT_POINTER_ENABLE_BIT = 4;
   localparam int DEFAULT_POINTER_START_LSB = 2;
   localparam int DEFAULT_BURST_LENGTH_BIT = 1;
   // Field position of the host-assigned code inside host_id_config
   localparam int HOST_ASSIGNED_CODE_LSB = 1;

   // Default pointer start code and burst sizes
   localparam logic [1:0] START_SENSED_TEMP_LOW = 2'h0;
   localparam logic [2:0] BURST_SHORT_BYTES = 3'h2;
   localparam logic [2:0] BURST_LONG_BYTES = 3'h4;

   // Register write strobe from the serial front end
   typedef struct packed {
      logic valid;
      logic [7:0] addr;
      logic [7:0] data;
   } reg_write_t;

   // Bus-level events decoded by the front end, one-cycle pulses
   typedef struct packed {
      logic busReset;
      logic resetDynamicAddr;
      logic setHostId;
      logic [2:0] setHostIdCode;
   } bus_event_t;

endpackage : sensor_cfg_pkg

// >>> logic/level_sync.sv
// Two-flop synchroniser for a level that comes from outside the mclk domain.
// Assumes the level holds for several mclk periods; the first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module level_sync (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Level in and out
   input wire logic levelIn,
   output logic levelOut
);

   logic stageOne;

   // Resets to a constant; the input is only caught on clock edges
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         stageOne <= 1'b0;
         levelOut <= 1'b0;
      end else begin
         stageOne <= levelIn;
         levelOut <= stageOne;
      end
   end

endmodule : level_sync
`default_nettype wire

// >>> logic/sensor_config_and_status_clear_regs.sv
// Configuration and status-clear register bank of a memory-module temperature sensor.
// Assumes a same-clock serial front end that delivers register writes, reads and CCC events;
// the protocol mode level arrives from the link side and is synchronised here.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Host-assigned code changes only on SETHID in I2C, RSTDAA in I3C, or bus reset.
// - Bus address is fixed 4-bit class prefix followed by 3-bit host-assigned code.
// - Address configuration register reads 0Eh after reset.
// - Bit 7 enables packet check, bit 6 disables parity check, both reset low.
// - RSTDAA or bus reset returns packet check and parity bits to defaults.
// - Bit 5 is read-only protocol indicator: 0 I2C, 1 I3C basic.
// - Bit 4 set makes reads start at the default register, else host pointer.
// - Bits 3:2 select default start; code 00 is sensed temperature low byte.
// - Bit 1 selects default burst length: 0 two bytes, 1 four bytes.
// - Writing ones to 13h bits 3..0 clears temperature status; bits read zero.
// - Register 13h is a command clearing latest temperature comparison status.
// - Writing ones to 14h bits 1,0 clears checksum and parity faults; read zero.
// - Error clear register acts only in I3C mode.
// - Default start register is sensed temperature low byte at 31h.
module sensor_config_and_status_clear_regs #(
   // Device-class prefix; value is arbitrary
   parameter logic [3:0] FIXED_CLASS_PREFIX = 4'ha
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Protocol mode from the link side, high for I3C basic
   input wire logic i3cModeIn,
   // Register access from the serial front end
   input wire sensor_cfg_pkg::reg_write_t regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadAddr,
   output logic [7:0] readData,
   // Bus events from the serial front end
   input wire sensor_cfg_pkg::bus_event_t busEvent,
   // Configuration outputs
   output logic [6:0] busAddress,
   output logic packetCheckEnable,
   output logic parityCheckDisable,
   output logic defaultPointerOn,
   output logic [7:0] defaultStartAddr,
   output logic [2:0] defaultBurstBytes,
   // Status clear pulses toward the status registers
   output logic [3:0] clearTempStatus,
   output logic [1:0] clearErrorStatus
);

   typedef struct packed {
      logic [2:0] hostAssignedCode;
      logic pktCheckOn;
      logic parityOff;
      logic ptrEn;
      logic [1:0] ptrStart;
      logic burstLong;
      logic [7:0] rdData;
      logic [3:0] clrTemp;
      logic [1:0] clrErr;
      logic [6:0] busAddr;
      logic [7:0] startAddr;
      logic [2:0] burstBytes;
   } state_t;

   state_t st;
   state_t next_st;
   logic rstSync1;
   logic rstLocal_n;
   logic i3cMode;

   // Reset release through two flops so every flop leaves reset on the same edge
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1 <= 1'b0;
         rstLocal_n <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstLocal_n <= rstSync1;
      end
   end

   // Mode level crosses from the link side
   level_sync modeSync (
      .mclk(mclk),
      .rst_n(rstLocal_n),
      .levelIn(i3cModeIn),
      .levelOut(i3cMode)
   );

   // Read-back images; reserved bits are zero
   function automatic logic [7:0] host_id_image(input logic [2:0] code);
      host_id_image = {4'h0, code, 1'b0};
   endfunction : host_id_image

   function automatic logic [7:0] device_config_image(input state_t s, input logic mode);
      device_config_image = {s.pktCheckOn, s.parityOff, mode, s.ptrEn, s.ptrStart, s.burstLong, 1'b0};
   endfunction : device_config_image

   // Next state
   always_comb begin
      next_st = st;
      next_st.clrTemp = 4'h0;
      next_st.clrErr = 2'h0;
      if (busEvent.busReset || (busEvent.resetDynamicAddr && i3cMode)) begin
         next_st.hostAssignedCode = sensor_cfg_pkg::HOST_ASSIGNED_CODE_RESET;
      end else if (busEvent.setHostId && !i3cMode) begin
         next_st.hostAssignedCode = busEvent.setHostIdCode;
      end
      // Configuration bit writes; reserved and read-only bits dropped
      if (regWrite.valid && regWrite.addr == sensor_cfg_pkg::DEVICE_CONFIG_ADDR) begin
         next_st.pktCheckOn = regWrite.data[sensor_cfg_pkg::PACKET_CHECK_ENABLE_BIT];
         next_st.parityOff = regWrite.data[sensor_cfg_pkg::PARITY_CHECK_DISABLE_BIT];
         next_st.ptrEn = regWrite.data[sensor_cfg_pkg::DEFAULT_POINTER_ENABLE_BIT];
         next_st.ptrStart = regWrite.data[sensor_cfg_pkg::DEFAULT_POINTER_START_LSB +: 2];
         // Stored as written; host keeps it unchanged in I2C mode
         next_st.burstLong = regWrite.data[sensor_cfg_pkg::DEFAULT_BURST_LENGTH_BIT];
      end
      // Defaults restored by RSTDAA or bus reset, winning over a write
      if (busEvent.busReset || busEvent.resetDynamicAddr) begin
         next_st.pktCheckOn = 1'b0;
         next_st.parityOff = 1'b0;
      end
      if (regWrite.valid && regWrite.addr == sensor_cfg_pkg::TEMP_STATUS_CLEAR_ADDR) begin
         next_st.clrTemp = regWrite.data[3:0];
      end
      // Error clear pulses only in I3C mode
      if (regWrite.valid && regWrite.addr == sensor_cfg_pkg::ERROR_STATUS_CLEAR_ADDR && i3cMode) begin
         next_st.clrErr = regWrite.data[1:0];
      end
      // Bus address follows the new code
      next_st.busAddr = {FIXED_CLASS_PREFIX, next_st.hostAssignedCode};
      // Only code 00 is defined; reserved codes fall back to it
      next_st.startAddr = sensor_cfg_pkg::SENSED_TEMP_LOW_BYTE_ADDR;
      next_st.burstBytes = next_st.burstLong ? sensor_cfg_pkg::BURST_LONG_BYTES
                                             : sensor_cfg_pkg::BURST_SHORT_BYTES;
      // Read mux; clear commands and unmapped offsets read zero
      if (!regRead) begin
         next_st.rdData = st.rdData;
      end else if (regReadAddr == sensor_cfg_pkg::HOST_ID_CONFIG_ADDR) begin
         next_st.rdData = host_id_image(st.hostAssignedCode);
      end else if (regReadAddr == sensor_cfg_pkg::DEVICE_CONFIG_ADDR) begin
         next_st.rdData = device_config_image(st, i3cMode);
      end else begin
         next_st.rdData = 8'h00;
      end
   end

   // State register
   always_ff @(posedge mclk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         st <= '{hostAssignedCode: sensor_cfg_pkg::HOST_ASSIGNED_CODE_RESET, pktCheckOn: 1'b0, parityOff: 1'b0,
                 ptrEn: 1'b0, ptrStart: sensor_cfg_pkg::START_SENSED_TEMP_LOW, burstLong: 1'b0,
                 rdData: 8'h00, clrTemp: 4'h0, clrErr: 2'h0,
                 busAddr: {FIXED_CLASS_PREFIX, sensor_cfg_pkg::HOST_ASSIGNED_CODE_RESET},
                 startAddr: sensor_cfg_pkg::SENSED_TEMP_LOW_BYTE_ADDR,
                 burstBytes: sensor_cfg_pkg::BURST_SHORT_BYTES};
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign readData = st.rdData;
   assign busAddress = st.busAddr;
   assign packetCheckEnable = st.pktCheckOn;
   assign parityCheckDisable = st.parityOff;
   assign defaultPointerOn = st.ptrEn;
   assign defaultStartAddr = st.startAddr;
   assign defaultBurstBytes = st.burstBytes;
   assign clearTempStatus = st.clrTemp;
   assign clearErrorStatus = st.clrErr;

   // Checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstLocal_n);

   sequence quietEvents;
      !busEvent.busReset && !busEvent.resetDynamicAddr && !busEvent.setHostId;
   endsequence

   sequence tempClearWrite;
      regWrite.valid && regWrite.addr == sensor_cfg_pkg::TEMP_STATUS_CLEAR_ADDR;
   endsequence

   sequence configWrite;
      regWrite.valid && regWrite.addr == sensor_cfg_pkg::DEVICE_CONFIG_ADDR;
   endsequence

   AST_HOST_CODE_STEADY: assert property (quietEvents |=> $stable(busAddress))
      else $error("host-assigned code changed without an event");
   AST_SETHID_ADDRESS: assert property ((busEvent.setHostId && !i3cMode && !busEvent.busReset &&
      !busEvent.resetDynamicAddr) |=> busAddress == {FIXED_CLASS_PREFIX, $past(busEvent.setHostIdCode)})
      else $error("bus address does not follow SETHID code");
   // Read lands two cycles after the reset pulse, with no event between
   AST_HOST_ID_RESET_READ: assert property (busEvent.busReset ##1 quietEvents ##1
      (regRead && regReadAddr == sensor_cfg_pkg::HOST_ID_CONFIG_ADDR) |=>
      readData == sensor_cfg_pkg::HOST_ID_CONFIG_RESET)
      else $error("address configuration not 0Eh after bus reset");
   AST_CHECK_DEFAULTS: assert property ((busEvent.busReset || busEvent.resetDynamicAddr) |=>
      !packetCheckEnable && !parityCheckDisable)
      else $error("packet check bits not restored");
   AST_PEC_WRITE: assert property ((configWrite and quietEvents) |=>
      packetCheckEnable == $past(regWrite.data[7]) && parityCheckDisable == $past(regWrite.data[6]))
      else $error("packet check bits not written");
   AST_PROTOCOL_BIT: assert property ((regRead && regReadAddr == sensor_cfg_pkg::DEVICE_CONFIG_ADDR) |=>
      readData[5] == $past(i3cMode) && readData[0] == 1'b0)
      else $error("protocol indicator read wrong");
   AST_DEFAULT_START: assert property (defaultPointerOn |-> defaultStartAddr == 8'h31)
      else $error("default start address wrong");
   AST_BURST_BYTES: assert property (configWrite |=>
      defaultBurstBytes == ($past(regWrite.data[1]) ? 3'h4 : 3'h2))
      else $error("burst length decode wrong");
   AST_TEMP_CLEAR_PULSE: assert property (tempClearWrite |=> clearTempStatus == $past(regWrite.data[3:0]))
      else $error("temperature clear pulse wrong");
   AST_TEMP_CLEAR_ENDS: assert property ((!regWrite.valid) |=> clearTempStatus == 4'h0)
      else $error("temperature clear pulse held");
   AST_ERR_CLEAR_MODE: assert property ((regWrite.valid &&
      regWrite.addr == sensor_cfg_pkg::ERROR_STATUS_CLEAR_ADDR) |=>
      clearErrorStatus == ($past(i3cMode) ? $past(regWrite.data[1:0]) : 2'h0))
      else $error("error clear pulse wrong");
   AST_CLEAR_READS_ZERO: assert property ((regRead &&
      (regReadAddr == sensor_cfg_pkg::TEMP_STATUS_CLEAR_ADDR ||
      regReadAddr == sensor_cfg_pkg::ERROR_STATUS_CLEAR_ADDR)) |=> readData == 8'h00)
      else $error("clear command register read not zero");
   AST_RESERVED_ZERO: assert property ((regRead && regReadAddr == sensor_cfg_pkg::HOST_ID_CONFIG_ADDR) |=>
      readData[7:4] == 4'h0 && readData[0] == 1'b0)
      else $error("reserved bits not zero");

endmodule : sensor_config_and_status_clear_regs
`default_nettype wire

// >>> bench/link_mode_model.sv
// Behavioural link-side partner that sets the protocol mode level.
// Assumes the bench asks for a mode; the level moves on a link clock edge.
`timescale 1ns/100ps
`default_nettype none
module link_mode_model (
   // Mode request from the bench
   input wire logic modeReq,
   // Mode level toward the device
   output logic i3cMode
);
   logic linkClk;

   // Link clock runs only while a change is pending, so it stands still otherwise
   initial begin
      linkClk = 1'b0;
      i3cMode = 1'b0;
      forever begin
         wait (modeReq != i3cMode);
         #62.5 linkClk = 1'b1;
         i3cMode = modeReq;
         #62.5 linkClk = 1'b0;
      end
   end
endmodule : link_mode_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench for the configuration and status-clear register bank.
// Assumes the same-clock strobe interface of the bank and the link-side mode model.
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
   $display("ERROR %0t: value %h expected %h", $time, (got), (exp)); end end
module testbench;
   localparam logic [3:0] PREFIX = 4'ha;
   logic mclk, rst_n, modeReq, i3cMode, regRead;
   logic [7:0] regReadAddr, readData, defaultStartAddr;
   sensor_cfg_pkg::reg_write_t regWrite;
   sensor_cfg_pkg::bus_event_t busEvent;
   logic [6:0] busAddress;
   logic packetCheckEnable, parityCheckDisable, defaultPointerOn;
   logic [2:0] defaultBurstBytes;
   logic [3:0] clearTempStatus, tempSeen;
   logic [1:0] clearErrorStatus, errSeen;
   int num_errors, num_checks;

   // Device under test and its link-side partner
   sensor_config_and_status_clear_regs #(.FIXED_CLASS_PREFIX(PREFIX)) sensor_config_and_status_clear_regs_i (
      .mclk(mclk), .rst_n(rst_n), .i3cModeIn(i3cMode), .regWrite(regWrite), .regRead(regRead),
      .regReadAddr(regReadAddr), .readData(readData), .busEvent(busEvent), .busAddress(busAddress),
      .packetCheckEnable(packetCheckEnable), .parityCheckDisable(parityCheckDisable),
      .defaultPointerOn(defaultPointerOn), .defaultStartAddr(defaultStartAddr),
      .defaultBurstBytes(defaultBurstBytes), .clearTempStatus(clearTempStatus),
      .clearErrorStatus(clearErrorStatus));
   link_mode_model link_mode_model_i (.modeReq(modeReq), .i3cMode(i3cMode));

   // 100 MHz clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   // Write strobe; the clear pulses are caught in the cycle they stand
   // One write per transaction, closed before the next begins
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regWrite = {1'b1, a, d};
      @(negedge mclk);
      regWrite = '0;
      tempSeen = clearTempStatus;
      errSeen = clearErrorStatus;
   endtask : wr

   // Read strobe; data is settled by the next falling edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(negedge mclk);
      regRead = 1'b1;
      regReadAddr = a;
      @(negedge mclk);
      regRead = 1'b0;
      `CHK(readData, exp)
   endtask : rd

   // Event pulse: {busReset, resetDynamicAddr, setHostId, code}
   task automatic ev(input logic [5:0] e);
      @(negedge mclk);
      busEvent = e;
      @(negedge mclk);
      busEvent = '0;
   endtask : ev

   task automatic stop_test;
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : stop_test

   // Watchdog at 20000 cycles, far beyond the under 200 cycles the tests need
   initial begin
      #200000;
      num_errors++;
      stop_test();
   end

   // Main sequence
   initial begin
      num_errors = 0;
      num_checks = 0;
      rst_n = 1'b0;
      modeReq = 1'b0;
      regRead = 1'b0;
      regReadAddr = '0;
      regWrite = '0;
      busEvent = '0;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rst_n = 1'b1;
      repeat (5) @(negedge mclk);
      // Reset state
      rd(8'h04, 8'h0e);
      rd(8'h12, 8'h00);
      `CHK(busAddress, {PREFIX, 3'h7})
      `CHK(defaultStartAddr, 8'h31)
      `CHK(defaultBurstBytes, 3'h2)
      // Plain writes never move the host code, SETHID does in I2C
      wr(8'h04, 8'h00);
      rd(8'h04, 8'h0e);
      ev(6'h0b);
      `CHK(busAddress, {PREFIX, 3'h3})
      rd(8'h04, 8'h06);
      // Indicator and reserved bits ignore writes; burst bit left alone in I2C
      wr(8'h12, 8'hf1);
      rd(8'h12, 8'hd0);
      `CHK({packetCheckEnable, parityCheckDisable}, 2'h3)
      `CHK(defaultPointerOn, 1'b1)
      // Error clear has no effect in I2C
      wr(8'h14, 8'h03);
      `CHK(errSeen, 2'h0)
      // Each temperature clear bit pulses only its own line
      for (int i = 0; i < 4; i++) begin
         wr(8'h13, 8'h01 << i);
         `CHK(tempSeen, 4'h1 << i)
      end
      wr(8'h13, 8'hf0);
      `CHK(tempSeen, 4'h0)
      rd(8'h13, 8'h00);
      rd(8'h50, 8'h00);
      // Bus reset restores the code and the check bits
      ev(6'h20);
      `CHK(busAddress, {PREFIX, 3'h7})
      rd(8'h04, 8'h0e);
      rd(8'h12, 8'h10);
      ev(6'h0d);
      // RSTDAA in I2C keeps the code but still drops the check bits
      wr(8'h12, 8'hc0);
      ev(6'h10);
      `CHK(busAddress, {PREFIX, 3'h5})
      rd(8'h12, 8'h00);
      // Move to I3C; the mode crosses the link clock and the synchroniser
      modeReq = 1'b1;
      repeat (40) @(negedge mclk);
      ev(6'h0a);
      `CHK(busAddress, {PREFIX, 3'h5})
      wr(8'h12, 8'hd2);
      rd(8'h12, 8'hf2);
      `CHK(defaultBurstBytes, 3'h4)
      `CHK(defaultStartAddr, 8'h31)
      for (int i = 0; i < 2; i++) begin
         wr(8'h14, 8'h01 << i);
         `CHK(errSeen, 2'h1 << i)
      end
      rd(8'h14, 8'h00);
      // RSTDAA in I3C restores the code and the check bits
      ev(6'h10);
      `CHK(busAddress, {PREFIX, 3'h7})
      rd(8'h12, 8'h32);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
